// ---- frc_top.sv ----
// under-temperature fault response and input over-voltage threshold logic
// ---------------------------------------------------------------
// Summary of operation
// - one-byte read-write action register at 54h
// - action register resets to BFh
// - retry timing counts in 35 ms units
// - under-temp fault drives alert, sets fault bit
// - fault bits clear only on clear command or reset
// - action 10 with retry 000 or 111 disables output, 111 then retries
// - action 11 off only while fault persists
// - retry 000 keeps output off until restart
// - retry 111 retries until commanded off
// - retry and hold recovery only after temperature above warn limit
// - attempt spacing from delay field plus one, times unit
// - word threshold register at 55h, reset D380h
// - threshold sets input over-voltage fault level
// - threshold is mantissa times two to exponent
// - spacing is delay field plus one, units
// - warning limit doubles as recovery threshold
// ---------------------------------------------------------------
module frc_top
  import frc_pkg::*;
#(
  parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC  // cycles in one retry unit
)(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CMD_STROBE,
  input  wire logic        CMD_WRITE,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [15:0] CMD_WDATA,
  output logic      [15:0] CMD_RDATA,
  output logic             CMD_ACK,
  output logic             CMD_ERR,
  input  wire logic        CLEAR_FAULTS,
  input  wire logic        RUN_CMD,
  input  wire logic        OTHER_SHUTDOWN,
  input  wire logic        UT_FAULT_DET,
  input  wire logic        ABOVE_UT_WARN,
  input  wire logic [15:0] VIN_MEAS,
  output logic             OUTPUT_EN,
  output logic             UT_FAULT_BIT,
  output logic             VIN_OV_FAULT_BIT,
  output logic             HOST_ALERT_LINE_N,
  output logic [7:0]       UT_ACTION,
  output logic [15:0]      VIN_OV_THRESHOLD
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            ut_action;   // action byte
    logic [15:0]           ov_thr;      // over-voltage threshold word
    logic [15:0]           rdata;       // read answer
    logic                  ack;         // access answered
    logic                  err;         // unknown command code
    logic                  ut_bit;      // latched under-temp fault
    logic                  ov_bit;      // latched over-voltage fault
    logic                  alert_n;     // alert line, low active
    logic                  out_en;      // output enable
    frc_state_t            st;          // output control state
    logic [UNIT_CNT_W-1:0] unit_cnt;    // cycles inside one unit
    logic [3:0]            units;       // whole units elapsed
  } frc_regs_t;

  frc_regs_t  s_reg;                    // registered state
  frc_regs_t  s_next;                   // next state
  logic       shuts;                    // configured code stops the output
  logic       act_while;                // action 11
  logic       unit_end;                 // last cycle of a unit
  logic [3:0] dly_units;                // delay field plus one
  frc_cmp_if  cmp_bus ();               // comparator carrier

  // ---------------------------------------------------------------
  // threshold compare
  // ---------------------------------------------------------------
  assign cmp_bus.meas  = VIN_MEAS;
  assign cmp_bus.limit = s_reg.ov_thr;
  frc_lin_cmp frc_lin_cmp_inst (
    .p (cmp_bus.cmp)
  );

  // ---------------------------------------------------------------
  // decode of the action byte
  // ---------------------------------------------------------------
  assign act_while = s_reg.ut_action[ACT_HI:ACT_LO] == ACT_WHILE_FAULT;
  // unused action or retry codes never stop the output
  assign shuts = act_while ||
                 (s_reg.ut_action[ACT_HI:ACT_LO] == ACT_RETRY &&
                  (s_reg.ut_action[RETRY_HI:RETRY_LO] == RETRY_NONE ||
                   s_reg.ut_action[RETRY_HI:RETRY_LO] == RETRY_FOREVER));
  assign dly_units = {1'b0, s_reg.ut_action[DLY_HI:DLY_LO]} + 4'h1;
  assign unit_end  = s_reg.unit_cnt == UNIT_CNT_W'(RETRY_UNIT_CYCLES - 1);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next     = s_reg;
    s_next.ack = 1'b0;
    s_next.err = 1'b0;
    // command access by code
    if (CMD_STROBE) begin
      s_next.ack = 1'b1;
      unique case (CMD_CODE)
        CODE_UT_ACTION: begin
          if (CMD_WRITE) begin
            s_next.ut_action = CMD_WDATA[7:0];
          end
          s_next.rdata = {8'h00, s_reg.ut_action};
        end
        CODE_VIN_OV_THR: begin
          if (CMD_WRITE) begin
            s_next.ov_thr = CMD_WDATA;
          end
          s_next.rdata = s_reg.ov_thr;
        end
        default: begin
          // unknown code: refused, answer zero
          s_next.err   = 1'b1;
          s_next.rdata = 16'h0000;
        end
      endcase
    end
    // sticky fault bits, a new event wins over the clear
    if (CLEAR_FAULTS) begin
      s_next.ut_bit = 1'b0;
      s_next.ov_bit = 1'b0;
    end
    if (UT_FAULT_DET) begin
      s_next.ut_bit = 1'b1;
    end
    if (cmp_bus.above) begin
      s_next.ov_bit = 1'b1;
    end
    s_next.alert_n = !(s_next.ut_bit || s_next.ov_bit);
    // output control
    unique case (s_reg.st)
      ST_IDLE: begin
        if (RUN_CMD && !OTHER_SHUTDOWN) begin
          s_next.st = ST_ON;
        end
      end
      ST_ON: begin
        if (!RUN_CMD || OTHER_SHUTDOWN) begin
          s_next.st = ST_IDLE;
        end else if (UT_FAULT_DET && shuts) begin
          if (act_while) begin
            s_next.st = ST_HOLD;
          end else if (s_reg.ut_action[RETRY_HI:RETRY_LO] == RETRY_NONE) begin
            s_next.st = ST_LATCH;
          end else begin
            s_next.st = ST_WAIT;
          end
        end
      end
      ST_HOLD: begin
        if (!RUN_CMD || OTHER_SHUTDOWN) begin
          s_next.st = ST_IDLE;
        end else if (ABOVE_UT_WARN) begin
          s_next.st = ST_ON;
        end
      end
      ST_LATCH: begin
        // only a restart through the off command leaves this state
        if (!RUN_CMD) begin
          s_next.st = ST_IDLE;
        end
      end
      ST_WAIT: begin
        s_next.unit_cnt = '0;
        s_next.units    = 4'h0;
        if (!RUN_CMD || OTHER_SHUTDOWN) begin
          s_next.st = ST_IDLE;
        end else if (ABOVE_UT_WARN) begin
          s_next.st = ST_DELAY;
        end
      end
      ST_DELAY: begin
        s_next.unit_cnt = unit_end ? '0 : s_reg.unit_cnt + 1'b1;
        if (!RUN_CMD || OTHER_SHUTDOWN) begin
          s_next.st = ST_IDLE;
        end else if (unit_end) begin
          s_next.units = s_reg.units + 4'h1;
          if (s_reg.units + 4'h1 == dly_units) begin
            s_next.st = ST_ON;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    s_next.out_en = s_next.st == ST_ON;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg           <= '0;
      s_reg.ut_action <= UT_ACTION_RST;
      s_reg.ov_thr    <= VIN_OV_THR_RST;
      s_reg.alert_n   <= 1'b1;
      s_reg.st        <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign CMD_RDATA         = s_reg.rdata;
  assign CMD_ACK           = s_reg.ack;
  assign CMD_ERR           = s_reg.err;
  assign OUTPUT_EN         = s_reg.out_en;
  assign UT_FAULT_BIT      = s_reg.ut_bit;
  assign VIN_OV_FAULT_BIT  = s_reg.ov_bit;
  assign HOST_ALERT_LINE_N = s_reg.alert_n;
  assign UT_ACTION         = s_reg.ut_action;
  assign VIN_OV_THRESHOLD  = s_reg.ov_thr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence wr_act_s;
    CMD_STROBE && CMD_WRITE && CMD_CODE == CODE_UT_ACTION;
  endsequence
  sequence fault_on_s;
    s_reg.st == ST_ON && RUN_CMD && !OTHER_SHUTDOWN && UT_FAULT_DET;
  endsequence

  act_write_a: assert property (wr_act_s |=> UT_ACTION == $past(CMD_WDATA[7:0]))
    else $error("action byte write not stored");
  thr_write_a: assert property (CMD_STROBE && CMD_WRITE && CMD_CODE == CODE_VIN_OV_THR
    |=> VIN_OV_THRESHOLD == $past(CMD_WDATA) && CMD_ACK)
    else $error("threshold write not stored");
  ut_alert_a: assert property (UT_FAULT_DET |=> UT_FAULT_BIT && !HOST_ALERT_LINE_N)
    else $error("under-temp fault did not raise alert");
  bit_hold_a: assert property (UT_FAULT_BIT && !CLEAR_FAULTS |=> UT_FAULT_BIT)
    else $error("fault bit cleared without clear command");
  ov_level_a: assert property (VIN_MEAS == VIN_OV_THRESHOLD |=> ##0
    (VIN_OV_FAULT_BIT == $past(VIN_OV_FAULT_BIT && !CLEAR_FAULTS)))
    else $error("over-voltage set at equal level");
  unused_code_a: assert property (fault_on_s ##0 !UT_ACTION[ACT_HI] |=> OUTPUT_EN)
    else $error("unused action code stopped output");
  latch_off_a: assert property (fault_on_s ##0 UT_ACTION[ACT_HI:RETRY_LO] == 5'h10
    |=> !OUTPUT_EN ##1 (!OUTPUT_EN || !$past(RUN_CMD, 1) || $past(s_reg.st) != ST_LATCH))
    else $error("no retry mode did not hold output off");
  hold_back_a: assert property (s_reg.st == ST_HOLD && RUN_CMD && !OTHER_SHUTDOWN
    && ABOVE_UT_WARN |=> OUTPUT_EN)
    else $error("hold mode did not recover");
  wait_warn_a: assert property (s_reg.st == ST_WAIT && !ABOVE_UT_WARN
    |=> s_reg.st != ST_DELAY && !OUTPUT_EN)
    else $error("retry started below warning limit");
  dly_end_a: assert property ($rose(OUTPUT_EN) && $past(s_reg.st) == ST_DELAY
    |-> $past(s_reg.units) == dly_units - 4'h1 && $past(unit_end))
    else $error("retry spacing wrong");
endmodule

// ---- frc_pkg.sv ----
// shared constants and types for the fault response configuration block
package frc_pkg;
  // ---------------------------------------------------------------
  // command codes of the two registers
  // ---------------------------------------------------------------
  localparam logic [7:0]  CODE_UT_ACTION   = 8'h54;    // under-temp fault action, one byte
  localparam logic [7:0]  CODE_VIN_OV_THR  = 8'h55;    // input over-voltage threshold, word
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  UT_ACTION_RST    = 8'hBF;    // disable and retry, continuous, 280 ms
  localparam logic [15:0] VIN_OV_THR_RST   = 16'hD380; // 14 V in linear format
  // ---------------------------------------------------------------
  // field positions of the action byte
  // ---------------------------------------------------------------
  localparam int          ACT_HI           = 7;        // action field msb
  localparam int          ACT_LO           = 6;        // action field lsb
  localparam int          RETRY_HI         = 5;        // retry field msb
  localparam int          RETRY_LO         = 3;        // retry field lsb
  localparam int          DLY_HI           = 2;        // delay field msb
  localparam int          DLY_LO           = 0;        // delay field lsb
  localparam logic [1:0]  ACT_RETRY        = 2'h2;     // disable then retry
  localparam logic [1:0]  ACT_WHILE_FAULT  = 2'h3;     // off only while fault persists
  localparam logic [2:0]  RETRY_NONE       = 3'h0;     // stay off until restarted
  localparam logic [2:0]  RETRY_FOREVER    = 3'h7;     // keep retrying
  // ---------------------------------------------------------------
  // linear word layout
  // ---------------------------------------------------------------
  localparam int          EXP_HI           = 15;       // exponent msb
  localparam int          EXP_LO           = 11;       // exponent lsb
  localparam int          MANT_HI          = 10;       // mantissa msb
  localparam int          FRAC_BITS        = 16;       // fixed point fraction bits
  localparam int          FIX_W            = 48;       // fixed point width
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 100;      // 10 MHz
  localparam int          RETRY_UNIT_MS    = 35;       // retry time unit
  localparam int          RETRY_UNIT_CYC   = (RETRY_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          UNIT_CNT_W       = 22;       // width of the unit counter
  // ---------------------------------------------------------------
  // output control states, gray along on, wait, delay
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,   // commanded off
    ST_ON    = 3'h1,   // output running
    ST_WAIT  = 3'h3,   // waiting for temperature above warning limit
    ST_DELAY = 3'h2,   // counting retry spacing
    ST_HOLD  = 3'h6,   // off while fault present
    ST_LATCH = 3'h7    // off until restarted
  } frc_state_t;
endpackage

// ---- frc_cmp_if.sv ----
// carrier between the top module and the linear value comparator
interface frc_cmp_if;
  logic [15:0] meas;   // measured input voltage, linear format
  logic [15:0] limit;  // threshold, linear format
  logic        above;  // meas strictly above limit
  modport cmp (input meas, input limit, output above);
  modport user (output meas, output limit, input above);
endinterface

// ---- frc_lin_cmp.sv ----
// comparator of two words held as signed mantissa times two to a signed exponent
module frc_lin_cmp
  import frc_pkg::*;
(
  frc_cmp_if.cmp p
);
  // ---------------------------------------------------------------
  // conversion to fixed point
  // ---------------------------------------------------------------
  // exponent in 15:11, mantissa in 10:0, both two's complement
  function automatic logic signed [FIX_W-1:0] to_fix(input logic [15:0] w);
    logic signed [FIX_W-1:0] m;
    logic        [5:0]       sh;
    m  = FIX_W'(signed'(w[MANT_HI:0]));
    sh = 6'(signed'(w[EXP_HI:EXP_LO]) + FRAC_BITS);
    return m <<< sh;
  endfunction

  // strict compare of the two values
  assign p.above = to_fix(p.meas) > to_fix(p.limit);
endmodule

// ---- frc_host_model.sv ----
// host controller model issuing command accesses to the block
module frc_host_model
  import frc_pkg::*;
(
  input  wire logic        clk,
  output logic             strobe,
  output logic             write,
  output logic [7:0]       code,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        ack,
  input  wire logic        err
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // command access
  // ---------------------------------------------------------------
  // lines idle low until the first access
  initial begin
    strobe = 1'b0;
    write  = 1'b0;
    code   = 8'h00;
    wdata  = 16'h0000;
  end
  // one access: request taken at a rising edge, answer read half a cycle on, at the next falling edge
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] rd, output logic e, output logic a);
    @(negedge clk);
    strobe = 1'b1;
    write  = w;
    code   = c;
    wdata  = d;
    @(negedge clk);
    rd     = rdata;
    e      = err;
    a      = ack;
    // released lines show a changed pattern, not the last value
    strobe = 1'b0;
    write  = ~write;
    code   = ~code;
    wdata  = ~wdata;
  endtask
endmodule

// ---- frc_top_tb.sv ----
// self-checking bench for the fault response configuration block
module frc_top_tb
  import frc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam int          U          = 6;  // shortened retry unit in cycles
  localparam logic [15:0] OV_TH [6]  = '{16'hCBC0, 16'hCBC0, 16'hD380,
                                         16'hD380, 16'hD380, 16'hD380};
  localparam logic [15:0] OV_VM [6]  = '{16'hD1E1, 16'hD1DF, 16'hD381,
                                         16'hD380, 16'hDB80, 16'hCBC1};
  localparam logic        OV_EX [6]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic        clk    = 1'b0;       // bench clock
  logic        arst_n = 1'b0;       // reset, held at start
  logic        clear  = 1'b0;       // clear-faults pulse
  logic        run    = 1'b1;       // output commanded on
  logic        shut   = 1'b0;       // other shutdown
  logic        det    = 1'b0;       // under-temp fault present
  logic        above  = 1'b1;       // temperature above warning limit
  logic [15:0] vin    = 16'h0000;   // measured input voltage
  logic        strobe, write, ack, err, en, ut_bit, ov_bit, alert_n;
  logic [7:0]  code, act;
  logic [15:0] wdata, rdata, thr;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // clock at 10 MHz
  always #50 clk = ~clk;
  frc_top #(.RETRY_UNIT_CYCLES(U)) frc_top_inst (
    .CLK(clk), .ARST_N(arst_n), .CMD_STROBE(strobe), .CMD_WRITE(write), .CMD_CODE(code),
    .CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_ACK(ack), .CMD_ERR(err),
    .CLEAR_FAULTS(clear), .RUN_CMD(run), .OTHER_SHUTDOWN(shut), .UT_FAULT_DET(det),
    .ABOVE_UT_WARN(above), .VIN_MEAS(vin), .OUTPUT_EN(en), .UT_FAULT_BIT(ut_bit),
    .VIN_OV_FAULT_BIT(ov_bit), .HOST_ALERT_LINE_N(alert_n), .UT_ACTION(act),
    .VIN_OV_THRESHOLD(thr));
  frc_host_model frc_host_model_inst (
    .clk(clk), .strobe(strobe), .write(write), .code(code), .wdata(wdata),
    .rdata(rdata), .ack(ack), .err(err));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] rd;
    logic        e, a;
    frc_host_model_inst.access(1'b1, c, d, rd, e, a);
  endtask
  task automatic reg_rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] rd;
    logic        e, a;
    frc_host_model_inst.access(1'b0, c, 16'h0000, rd, e, a);
    check("read data", exp, rd);
    check("read ack", 16'h0001, {15'h0000, a});
  endtask
  // output enable, under-temp bit and alert together
  task automatic chk_st(input logic e_en, input logic e_ut);
    check("output enable", {15'h0000, e_en}, {15'h0000, en});
    check("ut fault bit", {15'h0000, e_ut}, {15'h0000, ut_bit});
    check("alert line", {15'h0000, ~e_ut}, {15'h0000, alert_n});
  endtask
  task automatic clr;
    clear = 1'b1;
    tick(1);
    clear = 1'b0;
    tick(1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] rd;
    logic        e, a;
    check("action reg", 16'h00BF, {8'h00, act});
    check("threshold reg", 16'hD380, thr);
    reg_rd(CODE_UT_ACTION, 16'h00BF);
    reg_rd(CODE_VIN_OV_THR, 16'hD380);
    chk_st(1'b1, 1'b0);
    frc_host_model_inst.access(1'b1, 8'h56, 16'h1111, rd, e, a);
    check("unknown err", 16'h0001, {15'h0000, e});
    check("unknown rdata", 16'h0000, rd);
    $display("reset test done");
  endtask
  task automatic t_regs;
    reg_wr(CODE_UT_ACTION, 16'hAB38);
    check("action reg", 16'h0038, {8'h00, act});
    reg_rd(CODE_UT_ACTION, 16'h0038);
    reg_wr(CODE_VIN_OV_THR, 16'h1234);
    reg_rd(CODE_VIN_OV_THR, 16'h1234);
    $display("register test done");
  endtask
  // unused codes: only the bit and alert, latched until clear
  task automatic t_unused;
    logic [7:0] codes [3];
    codes = '{8'h38, 8'h50, 8'h90};
    foreach (codes[i]) begin
      reg_wr(CODE_UT_ACTION, {8'h00, codes[i]});
      above = 1'b0;
      det   = 1'b1;
      tick(1);
      det   = 1'b0;
      above = 1'b1;
      tick(1);
      chk_st(1'b1, 1'b1);
      reg_wr(CODE_UT_ACTION, 16'h00BF);
      tick(20);
      chk_st(1'b1, 1'b1);
      clr;
      chk_st(1'b1, 1'b0);
    end
    $display("unused code test done");
  endtask
  task automatic t_hold;
    reg_wr(CODE_UT_ACTION, 16'h00C0);
    above = 1'b0;
    det   = 1'b1;
    tick(1);
    chk_st(1'b0, 1'b1);
    det   = 1'b0;
    tick(10);
    chk_st(1'b0, 1'b1);
    above = 1'b1;
    tick(2);
    chk_st(1'b1, 1'b1);
    clr;
    $display("hold test done");
  endtask
  task automatic t_latch;
    reg_wr(CODE_UT_ACTION, 16'h0080);
    above = 1'b0;
    det   = 1'b1;
    tick(1);
    chk_st(1'b0, 1'b1);
    det   = 1'b0;
    above = 1'b1;
    tick(20);
    chk_st(1'b0, 1'b1);
    run   = 1'b0;
    tick(2);
    run   = 1'b1;
    tick(3);
    chk_st(1'b1, 1'b1);
    clr;
    $display("latch test done");
  endtask
  // continuous retry: waits for recovery, then (d+1) units
  task automatic t_retry(input logic [2:0] d);
    int n;
    reg_wr(CODE_UT_ACTION, {8'h00, 2'b10, 3'b111, d});
    above = 1'b0;
    det   = 1'b1;
    tick(1);
    chk_st(1'b0, 1'b1);
    det   = 1'b0;
    tick(60);
    chk_st(1'b0, 1'b1);
    above = 1'b1;
    n = 0;
    while (en !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("retry spacing in range", 16'h0001, {15'h0000,
          1'((n >= (int'(d) + 1) * U) && (n <= (int'(d) + 1) * U + 2))});
    clr;
    $display("retry test done, delay %0d, cycles %0d", d, n);
  endtask
  task automatic t_stop;
    reg_wr(CODE_UT_ACTION, 16'h00B8);
    above = 1'b0;
    det   = 1'b1;
    tick(1);
    det   = 1'b0;
    run   = 1'b0;
    tick(2);
    above = 1'b1;
    tick(20);
    chk_st(1'b0, 1'b1);
    run   = 1'b1;
    tick(3);
    chk_st(1'b1, 1'b1);
    shut  = 1'b1;
    tick(2);
    chk_st(1'b0, 1'b1);
    shut  = 1'b0;
    tick(3);
    chk_st(1'b1, 1'b1);
    clr;
    $display("stop test done");
  endtask
  // threshold compare across exponents, strictly above trips
  task automatic t_ov;
    for (int i = 0; i < 6; i++) begin
      reg_wr(CODE_VIN_OV_THR, OV_TH[i]);
      vin = OV_VM[i];
      tick(2);
      check("ov fault bit", {15'h0000, OV_EX[i]}, {15'h0000, ov_bit});
      check("alert line", {15'h0000, ~OV_EX[i]}, {15'h0000, alert_n});
      vin = 16'h0000;
      clr;
    end
    reg_wr(CODE_VIN_OV_THR, 16'hD380);
    $display("over-voltage test done");
  endtask
  // reset in mid-run restores both registers and the output state
  task automatic t_rerst;
    reg_wr(CODE_UT_ACTION, 16'h00C8);
    reg_wr(CODE_VIN_OV_THR, 16'h1234);
    det    = 1'b1;
    tick(1);
    det    = 1'b0;
    arst_n = 1'b0;
    tick(2);
    check("action reg", 16'h00BF, {8'h00, act});
    check("threshold reg", 16'hD380, thr);
    chk_st(1'b0, 1'b0);
    arst_n = 1'b1;
    tick(1);
    chk_st(1'b1, 1'b0);
    reg_rd(CODE_UT_ACTION, 16'h00BF);
    reg_rd(CODE_VIN_OV_THR, 16'hD380);
    $display("mid-run reset test done");
  endtask
  // ---------------------------------------------------------------
  // sequence and timeout
  // ---------------------------------------------------------------
  initial begin
    tick(2);
    arst_n = 1'b1;
    t_reset;
    t_regs;
    t_unused;
    t_hold;
    t_latch;
    t_retry(3'h0);
    t_retry(3'h7);
    t_stop;
    t_ov;
    t_rerst;
    stop_test;
  end
  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test;
    end
  end
endmodule
